// [hw/aai_alert_top.sv]
// Alert logic of the audio converter: sources, masks, latch and pin
`timescale 1ns/1ps
`include "aai_map.svh"

module aai_alert_top #(
    parameter int PULSE_CYC  = `AAI_PULSE_CYC,
    parameter int PERIOD_CYC = `AAI_PERIOD_CYC
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    // Register port, same clock as this block
    input  wire logic [7:0] reg_page,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata_ff,
    output logic            reg_rvalid_ff,
    // Event sources from other clock domains
    input  wire logic       audio_serial_port_clk_err,
    input  wire logic       pll_locked,
    // Alert pin
    output logic            alert_pin_ff
);
    import aai_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic hit(input logic [7:0] page,
                                 input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = (page == `AAI_PAGE_ZERO) && (addr == target);
    endfunction

    function automatic logic [7:0] rise(input logic [7:0] now,
                                        input logic [7:0] was);
        rise = now & ~was;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Source synchronisers

    logic [1:0] src_meta_ff;
    logic [1:0] src_sync_ff;
    logic [1:0] src_prev_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            src_meta_ff <= 2'h0;
            src_sync_ff <= 2'h0;
            src_prev_ff <= 2'h0;
        end else begin
            src_meta_ff <= {audio_serial_port_clk_err, pll_locked};
            src_sync_ff <= src_meta_ff;
            src_prev_ff <= src_sync_ff;
        end
    end

    logic [7:0] src_now;
    logic [7:0] src_was;
    logic [7:0] set_vec;

    always_comb begin
        src_now = 8'h00;
        src_was = 8'h00;
        src_now[`AAI_BIT_ASI] = src_sync_ff[1];
        src_now[`AAI_BIT_PLL] = src_sync_ff[0];
        src_was[`AAI_BIT_ASI] = src_prev_ff[1];
        src_was[`AAI_BIT_PLL] = src_prev_ff[0];
    end

    // Edge based, so a stuck error raises one event and not a flood
    assign set_vec = rise(src_now, src_was);                       // R9 R10

    ////////////////////////////////////////////////////////////////////
    // Register decode

    logic cfg_wr;
    logic mask_wr;
    logic ltch_rd;

    assign cfg_wr  = reg_wr && hit(reg_page, reg_addr, `AAI_ADDR_CFG); // R11
    assign mask_wr = reg_wr && hit(reg_page, reg_addr, `AAI_ADDR_MASK);
    assign ltch_rd = reg_rd && hit(reg_page, reg_addr, `AAI_ADDR_LTCH);

    ////////////////////////////////////////////////////////////////////
    // Configuration register

    logic [7:0] alert_config_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            alert_config_ff <= `AAI_CFG_RST;                       // R11
        end else if (cfg_wr) begin
            // Reserved bits stay zero
            alert_config_ff <= reg_wdata & `AAI_CFG_WMASK;
        end
    end

    logic        alert_polarity;
    logic        latch_readback_select;
    aai_evmode_t event_mode;

    assign alert_polarity        = alert_config_ff[`AAI_BIT_POL];
    assign latch_readback_select = alert_config_ff[`AAI_BIT_RDSEL];
    assign event_mode = aai_evmode_t'(
        alert_config_ff[`AAI_BIT_EVM_HI:`AAI_BIT_EVM_LO]);

    ////////////////////////////////////////////////////////////////////
    // Mask register

    logic [7:0] alert_mask_bank_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            alert_mask_bank_ff <= `AAI_MASK_RST;                   // R7 R8
        end else if (mask_wr) begin
            // Reserved low bits are writable storage too
            alert_mask_bank_ff <= reg_wdata;
        end
    end

    logic [7:0] unmasked;

    assign unmasked = ~alert_mask_bank_ff & `AAI_SRC_BITS;         // R7 R8

    ////////////////////////////////////////////////////////////////////
    // Latch register

    logic [7:0] alert_latch_bank_ff;
    logic [7:0] view_mask;
    logic [7:0] latch_view;
    logic [7:0] rd_clear;
    logic [7:0] nxt_latch;

    always_comb begin
        if (latch_readback_select) begin
            view_mask = unmasked;                                  // R6
        end else begin
            view_mask = `AAI_SRC_BITS;                             // R5
        end
        latch_view = alert_latch_bank_ff & view_mask;
        rd_clear   = ltch_rd ? latch_view : 8'h00;                 // R12
        // A set in the read cycle survives the clear
        nxt_latch  = (alert_latch_bank_ff & ~rd_clear) | set_vec;  // R12
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            alert_latch_bank_ff <= `AAI_LTCH_RST;                  // R9 R10
        end else begin
            alert_latch_bank_ff <= nxt_latch & `AAI_SRC_BITS;      // R9 R10
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read data

    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_page == `AAI_PAGE_ZERO) begin
            unique case (reg_addr)
                `AAI_ADDR_CFG:  nxt_rdata = alert_config_ff;
                `AAI_ADDR_MASK: nxt_rdata = alert_mask_bank_ff;
                `AAI_ADDR_LTCH: nxt_rdata = latch_view;            // R5 R6
                default:        nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_ff  <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alert shaping and pin

    logic pending;
    logic trigger;
    logic alert_active;

    assign pending = |(alert_latch_bank_ff & unmasked);            // R2 R3
    assign trigger = |(set_vec & unmasked);                        // R4

    aai_pulse_timer #(
        .PULSE_CYC  (PULSE_CYC),
        .PERIOD_CYC (PERIOD_CYC)
    ) u_timer (
        .clk       (clk),
        .resetn    (resetn),
        .mode      (event_mode),
        .pending   (pending),
        .trigger   (trigger),
        .active_ff (alert_active)
    );

    // Reset value is the idle level of the default active-low pin
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alert_pin_ff <= 1'b1;
        end else begin
            alert_pin_ff <= alert_polarity ? alert_active
                                           : ~alert_active;        // R1
        end
    end

endmodule // aai_alert_top

// [hw/aai_map.svh]
// Register map, field positions, reset values and timing counts
// Function
// R1 - The alert pin is active low when the polarity bit 7 of alert_config is 0 and active high when it is 1.
// R2 - Event mode 0 (bits 6-5) holds the alert asserted while any unmasked latched source is set; code 1 is reserved.
// R3 - Event mode 2 asserts the alert for 2 ms in every 4 ms while any unmasked latched source is set.
// R4 - Event mode 3 gives one 2 ms alert pulse for each new unmasked event.
// R5 - With readback select bit 2 at 0 the latch register shows every latched source, masked or not.
// R6 - With readback select bit 2 at 1 the latch register shows only unmasked sources and masked ones read 0.
// R7 - Mask bit 7 gates the audio serial port clock-error source, 1 masks, and resets to 1.
// R8 - Mask bit 6 gates the PLL-lock source, 1 masks, and resets to 1.
// R9 - Latch bit 7 sets on an audio serial port clock error, clears itself and resets to 0.
// R10 - Latch bit 6 sets when the PLL reports lock, clears itself and resets to 0.
// R11 - alert_config sits at page 0 address 0x32 and resets to 0x00.
// R12 - Reading the latch register clears the bits it returns, and an event in the same cycle stays latched.
// R13 - The 2 ms and 4 ms timings come from counters on the internal clock.
`ifndef AAI_MAP_SVH
`define AAI_MAP_SVH

`define AAI_PAGE_ZERO   8'h00
`define AAI_ADDR_CFG    8'h32
`define AAI_ADDR_MASK   8'h33
`define AAI_ADDR_LTCH   8'h36

`define AAI_CFG_RST     8'h00
`define AAI_MASK_RST    8'hff
`define AAI_LTCH_RST    8'h00

`define AAI_CFG_WMASK   8'he4
`define AAI_SRC_BITS    8'hc0
`define AAI_BIT_POL     7
`define AAI_BIT_EVM_HI  6
`define AAI_BIT_EVM_LO  5
`define AAI_BIT_RDSEL   2
`define AAI_BIT_ASI     7
`define AAI_BIT_PLL     6

`define AAI_CLK_HZ      10000000
`define AAI_PULSE_MS    2
`define AAI_PERIOD_MS   4
`define AAI_PULSE_CYC   (`AAI_PULSE_MS * (`AAI_CLK_HZ / 1000))
`define AAI_PERIOD_CYC  (`AAI_PERIOD_MS * (`AAI_CLK_HZ / 1000))

`endif

// [hw/aai_pkg.sv]
// Types shared by the alert logic
package aai_pkg;

    typedef enum logic [1:0] {
        AAI_EVM_LEVEL   = 2'b00,
        AAI_EVM_RSVD    = 2'b01,
        AAI_EVM_TRAIN   = 2'b10,
        AAI_EVM_ONESHOT = 2'b11
    } aai_evmode_t;

endpackage

// [hw/aai_pulse_timer.sv]
// Shapes the alert level into level, pulse train or one-shot form
`timescale 1ns/1ps
`include "aai_map.svh"

module aai_pulse_timer #(
    parameter int PULSE_CYC  = `AAI_PULSE_CYC,
    parameter int PERIOD_CYC = `AAI_PERIOD_CYC
) (
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire aai_pkg::aai_evmode_t mode,
    input  wire logic                pending,
    input  wire logic                trigger,
    output logic                     active_ff
);
    import aai_pkg::*;

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam logic [CW-1:0] PULSE_V = CW'(PULSE_CYC);
    localparam logic [CW-1:0] LAST_V  = CW'(PERIOD_CYC - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          nxt_active;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_cnt    = '0;
        nxt_active = 1'b0;
        unique case (mode)
            AAI_EVM_LEVEL, AAI_EVM_RSVD: begin
                nxt_active = pending;                              // R2
            end
            AAI_EVM_TRAIN: begin
                // Train restarts at phase 0 each time pending rises from clear, not when another source turns up while pending
                if (pending) begin
                    nxt_cnt = (cnt_ff == LAST_V) ? '0 : cnt_ff + 1'b1; // R13
                    nxt_active = cnt_ff < PULSE_V;                 // R3
                end
            end
            AAI_EVM_ONESHOT: begin
                // A new event during a pulse stretches it from that point
                if (trigger) begin
                    nxt_cnt = PULSE_V;                             // R4
                end else if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - 1'b1;                       // R13
                end
                nxt_active = nxt_cnt != '0;                        // R4
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_ff    <= '0;
            active_ff <= 1'b0;
        end else begin
            cnt_ff    <= nxt_cnt;
            active_ff <= nxt_active;
        end
    end

endmodule // aai_pulse_timer

// [verif/aai_alert_sva.sv]
// Port checker for the alert logic, bound into the top module
`timescale 1ns/1ps
module aai_alert_sva #(
    parameter int PULSE_CYC  = 4,
    parameter int PERIOD_CYC = 8
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic       reg_rvalid_ff,
    input wire logic       alert_pin_ff
);
    logic [7:0] cfg_ff;
    logic [7:0] mask_ff;
    int         quiet_ff;
    logic       sel;
    assign sel = reg_page == 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // Shadow copies from the write strobes only, never from read data
    always_ff @(posedge clk) begin
        if (!resetn)
            cfg_ff <= 8'h00;
        else if (sel && reg_wr && reg_addr == 8'h32)
            cfg_ff <= reg_wdata & 8'he4;
    end
    always_ff @(posedge clk) begin
        if (!resetn)
            mask_ff <= 8'hff;
        else if (sel && reg_wr && reg_addr == 8'h33)
            mask_ff <= reg_wdata;
    end
    // Long enough for any pulse or train phase to run out
    always_ff @(posedge clk) begin
        if (!resetn || reg_wr || mask_ff[7:6] != 2'b11)
            quiet_ff <= 0;
        else if (quiet_ff < 1000)
            quiet_ff <= quiet_ff + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_RST: assert property (disable iff (1'b0)
        !resetn |=> alert_pin_ff && !reg_rvalid_ff)
        else $error("pin or read valid wrong after reset");
    AST_RV: assert property (reg_rd |=> reg_rvalid_ff)
        else $error("read valid missing");
    AST_RV_ONE: assert property (!reg_rd |=> !reg_rvalid_ff)
        else $error("read valid without read");
    AST_UNMAP: assert property (reg_rd &&
        !(sel && reg_addr inside {8'h32, 8'h33, 8'h36})
        |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
    AST_CFG: assert property (reg_rd && sel && reg_addr == 8'h32
        |=> reg_rdata_ff == cfg_ff) else $error("config readback wrong");
    AST_MASK: assert property (reg_rd && sel && reg_addr == 8'h33
        |=> reg_rdata_ff == mask_ff) else $error("mask readback wrong");
    AST_LSEL: assert property (reg_rd && sel && reg_addr == 8'h36
        |=> reg_rdata_ff[5:0] == 6'h00 && (reg_rdata_ff
        & (cfg_ff[2] ? ~mask_ff : 8'hff)) == reg_rdata_ff)
        else $error("latch readback shows masked or reserved bits");
    AST_QUIET: assert property (
        quiet_ff > PERIOD_CYC + PULSE_CYC + 4
        |-> alert_pin_ff == !cfg_ff[7]) else $error("alert with all masked");
endmodule // aai_alert_sva
bind aai_alert_top aai_alert_sva #(.PULSE_CYC(PULSE_CYC),
    .PERIOD_CYC(PERIOD_CYC)) u_sva (.clk(clk), .resetn(resetn),
    .reg_page(reg_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .alert_pin_ff(alert_pin_ff));

// [verif/aai_host_model.sv]
// Host that watches the alert pin and counts its active cycles
`timescale 1ns/1ps
module aai_host_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        pol,
    input  wire logic        pin,
    output logic      [15:0] act_cnt
);
    always @(posedge clk) begin
        if (clr)
            act_cnt <= 16'h0000;
        else
            act_cnt <= act_cnt + 16'(pol ? pin : !pin);
    end
endmodule // aai_host_model

// [verif/tb_top.sv]
// Self-checking bench for the alert logic
`timescale 1ns/1ps
module tb_top;
    localparam int PC = 4;
    localparam int PR = 8;
    logic        clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic        asp = 1'b0, pll = 1'b0, hclr = 1'b0, hpol = 1'b0;
    logic [7:0]  page = 8'h00, addr = 8'h00, wdata = 8'h00, rdata, r;
    logic        rvalid, pin;
    logic [15:0] act;
    logic [7:0]  expq[$];
    int          bad_count = 0, n_checks = 0;
    always #50 clk = ~clk;
    aai_alert_top #(.PULSE_CYC(PC), .PERIOD_CYC(PR)) uut (.clk(clk),
        .resetn(resetn), .reg_page(page), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata_ff(rdata),
        .reg_rvalid_ff(rvalid), .audio_serial_port_clk_err(asp),
        .pll_locked(pll), .alert_pin_ff(pin));
    aai_host_model host (.clk(clk), .clr(hclr), .pol(hpol), .pin(pin),
        .act_cnt(act));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        // A read answer that never came is a failure too
        if (expq.size() != 0)
            bad_count++;
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
                          input logic [7:0] p = 8'h00);
        @(posedge clk);
        page <= p;
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        page <= 8'h00;
    endtask
    // Source held three cycles so the two-stage sync cannot miss it
    task automatic ev(input bit p);
        @(posedge clk);
        if (p)
            pll <= 1'b1;
        else
            asp <= 1'b1;
        repeat (3) @(posedge clk);
        pll <= 1'b0;
        asp <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic hc();
        @(posedge clk);
        hclr <= 1'b1;
        @(posedge clk);
        hclr <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Empty queue forces a mismatch: a read answer nobody asked for
    always @(posedge clk) begin
        #1;
        if (rvalid === 1'b1)
            chk(16'(rdata),
                expq.size() ? 16'(expq.pop_front()) : 16'h100);
    end
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
    initial begin
        r = 8'($urandom(32'h0831));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        wt(1);
        chk(16'(pin), 16'h0001);
        rd_reg(8'h32, 8'h00);
        rd_reg(8'h33, 8'hff);
        rd_reg(8'h36, 8'h00);
        rd_reg(8'h34, 8'h00);
        rd_reg(8'h32, 8'h00, 8'h01);
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom());
            wr_reg(8'h32, r);
            rd_reg(8'h32, r & 8'he4);
            r = 8'($urandom());
            wr_reg(8'h33, r);
            rd_reg(8'h33, r);
        end
        wr_reg(8'h32, 8'h00);
        wr_reg(8'h33, 8'hff);
        wr_reg(8'h36, 8'hff);
        ev(1);
        wt(4);
        chk(16'(pin), 16'h0001);
        rd_reg(8'h36, 8'h40);
        rd_reg(8'h36, 8'h00);
        ev(0);
        wr_reg(8'h32, 8'h04);
        rd_reg(8'h36, 8'h00);
        wr_reg(8'h32, 8'h00);
        rd_reg(8'h36, 8'h80);
        wr_reg(8'h33, 8'hbf);
        ev(1);
        wt(2);
        chk(16'(pin), 16'h0000);
        wr_reg(8'h32, 8'h80);
        wt(2);
        chk(16'(pin), 16'h0001);
        hpol <= 1'b1;
        rd_reg(8'h36, 8'h40);
        wt(4);
        chk(16'(pin), 16'h0000);
        wr_reg(8'h32, 8'hc0);
        ev(1);
        hc();
        wt(4 * PR);
        chk(act, 16'(4 * PC));
        rd_reg(8'h36, 8'h40);
        wt(2 * PR);
        hc();
        wt(2 * PR);
        chk(act, 16'h0000);
        wr_reg(8'h32, 8'he0);
        hc();
        ev(1);
        wt(2 * PR);
        chk(act, 16'(PC));
        wr_reg(8'h33, 8'h7f);
        hc();
        ev(1);
        ev(0);
        wt(2 * PR);
        chk(act, 16'(PC));
        // Latch now holds both sources, only the serial port one unmasked
        wr_reg(8'h32, 8'h04);
        rd_reg(8'h36, 8'h80);
        wr_reg(8'h32, 8'h00);
        // Read lands on the very edge that sets the same bit again
        fork
            ev(1);
            begin
                repeat (2) @(posedge clk);
                rd_reg(8'h36, 8'h40);
            end
        join
        rd_reg(8'h36, 8'h40);
        wt(2);
        wrap_up();
    end
endmodule // tb_top
